/* File: uehc_endpoint_ctrl.sv */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - No per-endpoint queues; packets up to 1280 bytes share one pool.
// - Sixteen endpoint control registers sit contiguously from the base offset.
// - Isochronous transmit: packet counts as sent unless aborted, completed without handshake.
// - Non-isochronous transmit: hold packet until host ACK, then release it.
// - Receive isochronous bit suppresses handshakes for OUT and SETUP.
// - Matching function address on an OUT or SETUP token starts page allocation for a new packet record.
// - Transmit code 00 silent, code 01 answers IN with STALL.
// - Transmit code 10 follows queue contents, code 11 always NAKs.
// - Receive code 00 silent, code 01 answers OUT with STALL.
// - Receive code 10 gives ACK or NAK by receive-permitted, 11 NAKs.
// - Transmit toggle flips only after a good non-isochronous send that has no parked write.
// - Read-only bit 0 keeps last received toggle, also for isochronous.
// - Token endpoint number selects the governing control register.
// - Writes to a busy endpoint wait for transaction end; last wins.
// - Unexpected toggle flagged when toggle repeats, never for isochronous.
module uehc_endpoint_ctrl
  import uehc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Register port.
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Token decoder.
  input wire logic tokenValid,
  input wire logic [1:0] tokenKind,
  input wire logic [6:0] tokenAddr,
  input wire logic [3:0] tokenEp,
  input wire logic [6:0] funcAddr,
  // Transmit queue and link status.
  input wire logic [15:0] txQueueHasData,
  input wire logic dataSent,
  input wire logic hostAck,
  input wire logic txnAbort,
  // Receive side status.
  input wire logic rxOk,
  input wire logic rxDone,
  input wire logic rxToggle,
  input wire logic rxCrcOk,
  // Handshake and data requests to the packet sender.
  output logic hsValid,
  output logic [1:0] hsCode,
  output logic txSend,
  output logic txPid,
  // Packet mover requests.
  output logic txComplete,
  output logic txRelease,
  output logic allocStart,
  output logic [3:0] allocEp,
  // Receive header fields.
  output logic hdrValid,
  output logic [3:0] hdrEp,
  output logic hdrTog,
  output logic hdrBadTog
);

  typedef struct packed {
    logic [EP_COUNT-1:0][7:0] ctrl;
    logic [EP_COUNT-1:0][7:0] pend;
    logic [EP_COUNT-1:0] pendV;
    uehc_state_t st;
    logic [3:0] ep;
    logic [7:0] rdData;
    logic hsValid;
    logic [1:0] hsCode;
    logic txSend;
    logic txPid;
    logic txComplete;
    logic txRelease;
    logic allocStart;
    logic hdrValid;
    logic [3:0] hdrEp;
    logic hdrTog;
    logic hdrBadTog;
  } uehc_regs_t;

  uehc_regs_t s_r;
  uehc_regs_t s_nxt;

  uehc_hs_if hs ();

  logic regHit;
  logic [EP_IDX_W-1:0] regIdx;
  logic addrMatch;
  logic [3:0] selEp;
  logic [7:0] selCtrl;
  logic curTxIso;
  logic curRxIso;
  logic badTog;
  logic endTxn;

  // The sixteen control bytes form one contiguous window.
  assign regHit = (regAddr >= EPC_BASE) && (regAddr <= EPC_LAST);
  assign regIdx = EP_IDX_W'(regAddr - EPC_BASE);

  // No address filtering beyond the function address is done here.
  assign addrMatch = tokenValid && (tokenAddr == funcAddr);

  // While idle the incoming token picks the register; later the latched one.
  assign selEp = (s_r.st == ST_IDLE) ? tokenEp : s_r.ep;
  assign selCtrl = s_r.ctrl[selEp];
  assign curTxIso = s_r.ctrl[s_r.ep][TX_ISO_BIT];
  assign curRxIso = s_r.ctrl[s_r.ep][RX_ISO_BIT];

  // Handshake decision for the selected endpoint.
  assign hs.ctrl = selCtrl;
  assign hs.isIn = (s_r.st == ST_IDLE) && (tokenKind == TOK_IN);
  assign hs.txHasData = txQueueHasData[selEp];
  assign hs.rxOk = rxOk;
  assign hs.crcOk = rxCrcOk;

  uehc_hs_select hsSel (
    .hs(hs.decide)
  );

  // Toggle check compares against the toggle stored before this packet.
  uehc_tog_check togChk (
    .lastTog(s_r.ctrl[s_r.ep][RX_TOG_BIT]),
    .curTog(rxToggle),
    .rxIso(curRxIso),
    .badTog(badTog)
  );

  // Next-state logic for registers, sequencer and request pulses.
  always_comb begin
    s_nxt = s_r;
    endTxn = 1'b0;
    s_nxt.hsValid = 1'b0;
    s_nxt.txSend = 1'b0;
    s_nxt.txComplete = 1'b0;
    s_nxt.txRelease = 1'b0;
    s_nxt.allocStart = 1'b0;
    s_nxt.hdrValid = 1'b0;
    s_nxt.rdData = 8'h00;
    if (regRd && regHit) begin
      s_nxt.rdData = s_r.ctrl[regIdx];
    end
    // A busy endpoint parks the write; a later write simply overwrites it.
    if (regWr && regHit) begin
      if ((s_r.st != ST_IDLE) && (regIdx == s_r.ep)) begin
        s_nxt.pend[regIdx] = regWrData;
        s_nxt.pendV[regIdx] = 1'b1;
      end else begin
        s_nxt.ctrl[regIdx] = {regWrData[7:1], s_r.ctrl[regIdx][RX_TOG_BIT]};
      end
    end
    case (s_r.st)
      ST_IDLE: begin
        if (addrMatch) begin
          s_nxt.ep = tokenEp;
          if (tokenKind == TOK_IN) begin
            if (hs.sendData) begin
              s_nxt.txSend = 1'b1;
              s_nxt.txPid = selCtrl[TX_TOG_BIT];
              s_nxt.st = ST_IN_DATA;
            end else begin
              s_nxt.hsValid = hs.respond;
              s_nxt.hsCode = hs.code;
            end
          end else begin
            // Every endpoint feeds the one shared pool.
            s_nxt.allocStart = 1'b1;
            s_nxt.st = ST_OUT_DATA;
          end
        end
      end
      ST_IN_DATA: begin
        if (txnAbort) begin
          endTxn = 1'b1;
        end else if (curTxIso && dataSent) begin
          s_nxt.txComplete = 1'b1;
          endTxn = 1'b1;
        end else if (!curTxIso && hostAck) begin
          s_nxt.txComplete = 1'b1;
          s_nxt.txRelease = 1'b1;
          s_nxt.ctrl[s_r.ep][TX_TOG_BIT] = !s_r.ctrl[s_r.ep][TX_TOG_BIT];
          endTxn = 1'b1;
        end
      end
      ST_OUT_DATA: begin
        if (txnAbort) begin
          endTxn = 1'b1;
        end else if (rxDone) begin
          s_nxt.hdrValid = 1'b1;
          s_nxt.hdrEp = s_r.ep;
          s_nxt.hdrTog = rxToggle;
          s_nxt.hdrBadTog = badTog;
          s_nxt.ctrl[s_r.ep][RX_TOG_BIT] = rxToggle;
          s_nxt.hsValid = hs.respond;
          s_nxt.hsCode = hs.code;
          endTxn = 1'b1;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // Parked writes land only now; hardware still owns the receive toggle.
    if (endTxn) begin
      s_nxt.st = ST_IDLE;
      if (s_nxt.pendV[s_r.ep]) begin
        s_nxt.ctrl[s_r.ep] = {s_nxt.pend[s_r.ep][7:1],
                              s_nxt.ctrl[s_r.ep][RX_TOG_BIT]};
        s_nxt.pendV[s_r.ep] = 1'b0;
      end
    end
  end

  // Single state register; reset leaves every endpoint disabled.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctrl <= {EP_COUNT{EPC_RESET}};
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // All outputs come straight from the state register.
  assign regRdData = s_r.rdData;
  assign hsValid = s_r.hsValid;
  assign hsCode = s_r.hsCode;
  assign txSend = s_r.txSend;
  assign txPid = s_r.txPid;
  assign txComplete = s_r.txComplete;
  assign txRelease = s_r.txRelease;
  assign allocStart = s_r.allocStart;
  assign allocEp = s_r.ep;
  assign hdrValid = s_r.hdrValid;
  assign hdrEp = s_r.hdrEp;
  assign hdrTog = s_r.hdrTog;
  assign hdrBadTog = s_r.hdrBadTog;

  // Checks on the sequencer and the decode.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  logic [1:0] selTxRsp;
  logic [1:0] curRxRsp;
  assign selTxRsp = {selCtrl[TX_RSP_HI], selCtrl[TX_RSP_LO]};
  assign curRxRsp = {s_r.ctrl[s_r.ep][RX_RSP_HI], s_r.ctrl[s_r.ep][RX_RSP_LO]};

  // A firmware write that lands at transaction end overrides the toggle.
  logic epWrBusy;
  assign epWrBusy = s_r.pendV[s_r.ep] ||
                    (regWr && regHit && (regIdx == s_r.ep));

  sequence sInToken;
    (s_r.st == ST_IDLE) && addrMatch && (tokenKind == TOK_IN);
  endsequence

  sequence sAckTaken;
    (s_r.st == ST_IN_DATA) && !curTxIso && hostAck && !txnAbort && !epWrBusy;
  endsequence

  sequence sRxEnd;
    (s_r.st == ST_OUT_DATA) && rxDone && !txnAbort;
  endsequence

  AST_RESET_CLEAR: assert property (
    @(posedge core_clk) disable iff (1'b0)
    reset |=> (s_r.ctrl == '0) && !hsValid && !txSend)
    else $error("Control registers not cleared by reset.");

  AST_IN_STALL: assert property (
    sInToken and (selTxRsp == RSP_STALL) |=> hsValid && (hsCode == HS_STALL))
    else $error("IN to stalled endpoint not answered with STALL.");

  AST_IN_OFF: assert property (
    sInToken and (selTxRsp == RSP_OFF) |=> !hsValid && !txSend)
    else $error("Disabled transmit endpoint answered.");

  AST_IN_NAK: assert property (
    sInToken and (selTxRsp == RSP_NAK) |=>
      hsValid && (hsCode == HS_NAK) && !txSend)
    else $error("Forced NAK endpoint did not NAK.");

  AST_ISO_DONE: assert property (
    (s_r.st == ST_IN_DATA) && curTxIso && dataSent && !txnAbort |=>
      txComplete && !txRelease && (s_r.st == ST_IDLE))
    else $error("Isochronous packet not completed at send end.");

  AST_ACK_RELEASE: assert property (
    sAckTaken |=> txComplete && txRelease)
    else $error("Acknowledged packet not released.");

  AST_TOG_FLIP: assert property (
    sAckTaken |=> s_r.ctrl[$past(s_r.ep)][TX_TOG_BIT] !=
      $past(s_r.ctrl[s_r.ep][TX_TOG_BIT]))
    else $error("Transmit toggle did not flip after ACK.");

  AST_RX_ISO_QUIET: assert property (
    sRxEnd and curRxIso |=> !hsValid ##1 !hsValid)
    else $error("Handshake sent on isochronous receive.");

  AST_OUT_NORMAL: assert property (
    sRxEnd and !curRxIso && rxCrcOk && (curRxRsp == RSP_NORMAL) |=>
      hsValid && (hsCode == ($past(rxOk) ? HS_ACK : HS_NAK)))
    else $error("Normal receive answer does not follow receive-permitted.");

  AST_OUT_STALL: assert property (
    sRxEnd and !curRxIso && rxCrcOk && (curRxRsp == RSP_STALL) |=>
      hsValid && (hsCode == HS_STALL))
    else $error("OUT to stalled endpoint not answered with STALL.");

  AST_RX_TOG: assert property (
    sRxEnd |=> (s_r.ctrl[hdrEp][RX_TOG_BIT] == hdrTog) && hdrValid)
    else $error("Received toggle not recorded.");

  AST_ISO_NO_BADTOG: assert property (
    sRxEnd and curRxIso |=> !hdrBadTog)
    else $error("Unexpected toggle flagged on isochronous receive.");

  AST_ALLOC: assert property (
    (s_r.st == ST_IDLE) && addrMatch && (tokenKind != TOK_IN) |=>
      allocStart && (s_r.st == ST_OUT_DATA))
    else $error("Address match did not start allocation.");

  AST_DEFER: assert property (
    regWr && regHit && (s_r.st != ST_IDLE) && (regIdx == s_r.ep) &&
      !endTxn |=>
      s_r.ctrl[$past(regIdx)][7:2] == $past(s_r.ctrl[regIdx][7:2]))
    else $error("Write to busy endpoint took effect early.");

  AST_IN_SEND: assert property (
    sInToken and (selTxRsp == RSP_NORMAL) && txQueueHasData[selEp] |=>
      txSend && !hsValid && (txPid == $past(selCtrl[TX_TOG_BIT])))
    else $error("Queued data not sent on normal IN endpoint.");

  AST_ISO_TOG_KEEP: assert property (
    (s_r.st == ST_IN_DATA) && curTxIso && !epWrBusy |=>
      s_r.ctrl[$past(s_r.ep)][TX_TOG_BIT] ==
        $past(s_r.ctrl[s_r.ep][TX_TOG_BIT]))
    else $error("Transmit toggle changed on isochronous send.");

endmodule

/* File: uehc_pkg.sv */
package uehc_pkg;

  // Endpoint control register window.
  localparam int EP_COUNT = 16;
  localparam int EP_IDX_W = 4;
  localparam logic [15:0] EPC_BASE = 16'h7f80;
  localparam logic [15:0] EPC_LAST = 16'h7f8f;
  localparam logic [7:0] EPC_RESET = 8'h00;

  // Largest payload that the shared buffer pool accepts.
  localparam int MAX_PAYLOAD_BYTES = 1280;

  // Bit positions inside one endpoint control byte.
  localparam int TX_ISO_BIT = 7;
  localparam int RX_ISO_BIT = 6;
  localparam int TX_RSP_HI = 5;
  localparam int RX_RSP_HI = 4;
  localparam int TX_RSP_LO = 3;
  localparam int RX_RSP_LO = 2;
  localparam int TX_TOG_BIT = 1;
  localparam int RX_TOG_BIT = 0;

  // Transmit and receive response code values.
  localparam logic [1:0] RSP_OFF = 2'h0;
  localparam logic [1:0] RSP_STALL = 2'h1;
  localparam logic [1:0] RSP_NORMAL = 2'h2;
  localparam logic [1:0] RSP_NAK = 2'h3;

  // Handshake codes handed to the packet sender.
  localparam logic [1:0] HS_ACK = 2'h1;
  localparam logic [1:0] HS_NAK = 2'h2;
  localparam logic [1:0] HS_STALL = 2'h3;

  // Token kinds from the token decoder.
  localparam logic [1:0] TOK_OUT = 2'h0;
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;

  // Transaction sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_IN_DATA,
    ST_OUT_DATA
  } uehc_state_t;

endpackage

/* File: uehc_hs_if.sv */
`timescale 1ns/1ps
interface uehc_hs_if;
  import uehc_pkg::*;

  // Endpoint settings and link status feeding the decision.
  logic [7:0] ctrl;
  logic isIn;
  logic txHasData;
  logic rxOk;
  logic crcOk;
  // The decision itself.
  logic sendData;
  logic respond;
  logic [1:0] code;

  modport decide (
    input ctrl, isIn, txHasData, rxOk, crcOk,
    output sendData, respond, code
  );
  modport user (
    output ctrl, isIn, txHasData, rxOk, crcOk,
    input sendData, respond, code
  );
endinterface

/* File: uehc_hs_select.sv */
`timescale 1ns/1ps
module uehc_hs_select
  import uehc_pkg::*;
(
  // Decision carrier.
  uehc_hs_if.decide hs
);

  logic [1:0] txRsp;
  logic [1:0] rxRsp;

  // Pull the two split response fields out of the control byte.
  assign txRsp = {hs.ctrl[TX_RSP_HI], hs.ctrl[TX_RSP_LO]};
  assign rxRsp = {hs.ctrl[RX_RSP_HI], hs.ctrl[RX_RSP_LO]};

  // Pick the answer; a disabled endpoint stays silent so the host times out.
  always_comb begin
    hs.sendData = 1'b0;
    hs.respond = 1'b0;
    hs.code = HS_NAK;
    if (hs.isIn) begin
      case (txRsp)
        RSP_STALL: begin
          hs.respond = 1'b1;
          hs.code = HS_STALL;
        end
        RSP_NORMAL: begin
          hs.sendData = hs.txHasData;
          hs.respond = !hs.txHasData;
        end
        RSP_NAK: begin
          hs.respond = 1'b1;
        end
        default: begin
          hs.respond = 1'b0;
        end
      endcase
    end else if (!hs.ctrl[RX_ISO_BIT] && hs.crcOk) begin
      case (rxRsp)
        RSP_STALL: begin
          hs.respond = 1'b1;
          hs.code = HS_STALL;
        end
        RSP_NORMAL: begin
          hs.respond = 1'b1;
          hs.code = hs.rxOk ? HS_ACK : HS_NAK;
        end
        RSP_NAK: begin
          hs.respond = 1'b1;
        end
        default: begin
          hs.respond = 1'b0;
        end
      endcase
    end
  end

endmodule

/* File: uehc_tog_check.sv */
`timescale 1ns/1ps
module uehc_tog_check (
  // Toggle history and mode.
  input wire logic lastTog,
  input wire logic curTog,
  input wire logic rxIso,
  // Result.
  output logic badTog
);

  // A repeated toggle usually means our handshake was lost, not corruption.
  assign badTog = !rxIso && (lastTog == curTog);

endmodule

/* File: uehc_host_model.sv */
`timescale 1ns/1ps
module uehc_host_model
  import uehc_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // Behaviour knobs from the bench.
  input wire logic isoMode,
  input wire logic ackOn,
  input wire logic [3:0] gap,
  // Data request from the device.
  input wire logic txSend,
  // Token, handshake and data packet events.
  output logic tokenValid,
  output logic [1:0] tokenKind,
  output logic [6:0] tokenAddr,
  output logic [3:0] tokenEp,
  output logic dataSent,
  output logic hostAck,
  output logic txnAbort,
  output logic rxDone,
  output logic rxToggle,
  output logic rxCrcOk
);
  // Pulses idle low from time zero.
  initial begin
    tokenValid = 1'b0;
    tokenKind = 2'h0;
    tokenAddr = 7'h00;
    tokenEp = 4'h0;
    dataSent = 1'b0;
    hostAck = 1'b0;
    txnAbort = 1'b0;
    rxDone = 1'b0;
    rxToggle = 1'b0;
    rxCrcOk = 1'b0;
  end

  // Fields show their inverse once the strobe drops, so nothing can
  // lean on a stale token.
  task automatic token(input logic [1:0] k, input logic [3:0] e,
                       input logic [6:0] a);
    @(posedge core_clk);
    tokenValid <= 1'b1;
    tokenKind <= k;
    tokenEp <= e;
    tokenAddr <= a;
    @(posedge core_clk);
    tokenValid <= 1'b0;
    tokenKind <= ~k;
    tokenEp <= ~e;
    tokenAddr <= ~a;
  endtask

  // An OUT or SETUP data packet ends n cycles after the call.
  task automatic outData(input logic tog, input logic crc, input int n);
    repeat (n) @(posedge core_clk);
    rxDone <= 1'b1;
    rxToggle <= tog;
    rxCrcOk <= crc;
    @(posedge core_clk);
    rxDone <= 1'b0;
    rxToggle <= ~tog;
    rxCrcOk <= ~crc;
  endtask

  // The data packet crosses the wire in gap cycles; a silent host makes
  // the device give up instead of acknowledging.
  initial begin
    forever begin
      @(posedge core_clk);
      if (txSend === 1'b1) begin
        repeat (gap) @(posedge core_clk);
        dataSent <= 1'b1;
        @(posedge core_clk);
        dataSent <= 1'b0;
        if (isoMode !== 1'b1) begin
          repeat (gap) @(posedge core_clk);
          hostAck <= ackOn;
          txnAbort <= ~ackOn;
          @(posedge core_clk);
          hostAck <= 1'b0;
          txnAbort <= 1'b0;
        end
      end
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import uehc_pkg::*;
  // One decision row; flg is address match, queue data, rx ok, CRC good.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] kind;
    logic [3:0] flg;
    logic [2:0] hs;
    logic send;
  } uehc_row_t;
  logic core_clk, reset, regWr, regRd, rxOk, hostIso, ackOn;
  logic [15:0] regAddr, txQueueHasData;
  logic [7:0] regWrData, regRdData;
  logic [6:0] tokenAddr, funcAddr;
  logic [3:0] tokenEp, allocEp, hdrEp, gap;
  logic [1:0] tokenKind, hsCode;
  logic tokenValid, dataSent, hostAck, txnAbort, rxDone, rxToggle;
  logic rxCrcOk, hsValid, txSend, txPid, txComplete, txRelease;
  logic allocStart, hdrValid, hdrTog, hdrBadTog;
  int error_cnt, checks, cmpCnt, relCnt;
  uehc_row_t rows [16];
  uehc_row_t r;

  uehc_endpoint_ctrl dut (.core_clk(core_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .tokenValid(tokenValid),
    .tokenKind(tokenKind), .tokenAddr(tokenAddr), .tokenEp(tokenEp),
    .funcAddr(funcAddr), .txQueueHasData(txQueueHasData),
    .dataSent(dataSent), .hostAck(hostAck), .txnAbort(txnAbort),
    .rxOk(rxOk), .rxDone(rxDone), .rxToggle(rxToggle),
    .rxCrcOk(rxCrcOk), .hsValid(hsValid), .hsCode(hsCode),
    .txSend(txSend), .txPid(txPid), .txComplete(txComplete),
    .txRelease(txRelease), .allocStart(allocStart), .allocEp(allocEp),
    .hdrValid(hdrValid), .hdrEp(hdrEp), .hdrTog(hdrTog),
    .hdrBadTog(hdrBadTog));

  uehc_host_model host (.core_clk(core_clk), .isoMode(hostIso),
    .ackOn(ackOn), .gap(gap), .txSend(txSend), .tokenValid(tokenValid),
    .tokenKind(tokenKind), .tokenAddr(tokenAddr), .tokenEp(tokenEp),
    .dataSent(dataSent), .hostAck(hostAck), .txnAbort(txnAbort),
    .rxDone(rxDone), .rxToggle(rxToggle), .rxCrcOk(rxCrcOk));

  // Clock at 100 ns; a hang is cut off after 50000 cycles.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #5000000;
    error_cnt++;
    $display("[ERR] run length expected end seen hang");
    conclude();
  end

  // Completion pulses are counted so slow answers are not missed.
  always @(posedge core_clk) begin
    if (txComplete === 1'b1) cmpCnt++;
    if (txRelease === 1'b1) relCnt++;
  end

  task automatic conclude();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string n, input logic [7:0] e,
                       input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic regWrite(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic chkRd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 check("regRdData", e, regRdData);
  endtask

  // Bounded wait for the completion pulse, then both pulse counts.
  task automatic waitDone(input logic expC, input logic expR);
    int c0, r0, n;
    c0 = cmpCnt;
    r0 = relCnt;
    n = 0;
    while (cmpCnt == c0 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    if (expC === 1'b1 && n == 60) begin
      error_cnt++;
      $display("[ERR] txComplete expected 1 seen 0");
      conclude();
    end
    repeat (2) @(posedge core_clk);
    check("txComplete", expC, 8'(cmpCnt != c0));
    check("txRelease", expR, 8'(relCnt != r0));
  endtask

  // OUT on one endpoint, then the header that the device records.
  task automatic outTxn(input logic [3:0] e, input logic tog,
                        input logic bad);
    host.token(TOK_OUT, e, funcAddr);
    #1 check("allocStart", 8'h01, allocStart);
    check("allocEp", e, allocEp);
    host.outData(tog, 1'b1, 3);
    #1 check("hdrValid", 8'h01, hdrValid);
    check("hdrEp", e, hdrEp);
    check("hdrTog", tog, hdrTog);
    check("hdrBadTog", bad, hdrBadTog);
  endtask

  task automatic doReset();
    reset <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
  endtask

  initial begin
    {reset, regWr, regRd, hostIso} = 4'h8;
    {regAddr, regWrData, txQueueHasData} = 40'h0;
    {rxOk, ackOn, gap, funcAddr} = {2'h3, 4'h2, 7'h2a};
    rows[0] = {8'h00, TOK_IN, 4'hf, 3'h0, 1'b0};
    rows[1] = {8'h08, TOK_IN, 4'hf, 3'h7, 1'b0};
    rows[2] = {8'h20, TOK_IN, 4'hf, 3'h0, 1'b1};
    rows[3] = {8'h20, TOK_IN, 4'hb, 3'h6, 1'b0};
    rows[4] = {8'h28, TOK_IN, 4'hf, 3'h6, 1'b0};
    rows[5] = {8'h00, TOK_OUT, 4'hf, 3'h0, 1'b0};
    rows[6] = {8'h04, TOK_OUT, 4'hf, 3'h7, 1'b0};
    rows[7] = {8'h10, TOK_OUT, 4'hf, 3'h5, 1'b0};
    rows[8] = {8'h10, TOK_OUT, 4'hd, 3'h6, 1'b0};
    rows[9] = {8'h14, TOK_OUT, 4'hf, 3'h6, 1'b0};
    rows[10] = {8'h50, TOK_OUT, 4'hf, 3'h0, 1'b0};
    rows[11] = {8'h50, TOK_SETUP, 4'hf, 3'h0, 1'b0};
    rows[12] = {8'h10, TOK_SETUP, 4'hf, 3'h5, 1'b0};
    rows[13] = {8'h10, TOK_OUT, 4'he, 3'h0, 1'b0};
    rows[14] = {8'h10, TOK_OUT, 4'h7, 3'h0, 1'b0};
    rows[15] = {8'h20, TOK_IN, 4'h7, 3'h0, 1'b0};
    doReset();
    for (int i = 0; i < 16; i++) begin
      chkRd(EPC_BASE + 16'(i), EPC_RESET);
    end
    // Decision table, one endpoint per row.
    for (int i = 0; i < 16; i++) begin
      r = rows[i];
      regWrite(EPC_BASE + 16'(i), r.ctrl);
      txQueueHasData <= 16'(r.flg[2]) << i;
      rxOk <= r.flg[1];
      host.token(r.kind, 4'(i), r.flg[3] ? funcAddr : ~funcAddr);
      if (r.kind != TOK_IN) host.outData(1'b1, r.flg[0], 2);
      #1 check("hsValid", r.hs[2], hsValid);
      if (r.hs[2]) check("hsCode", r.hs[1:0], hsCode);
      check("txSend", r.send, txSend);
      if (r.send) begin
        check("txPid", 8'h00, txPid);
        waitDone(1'b1, 1'b1);
        chkRd(EPC_BASE + 16'(i), r.ctrl | 8'h02);
      end
    end
    // Isochronous IN completes on the wire, keeps its toggle.
    regWrite(EPC_BASE + 16'h2, 8'h02);
    regWrite(EPC_BASE + 16'h2, 8'ha0);
    txQueueHasData <= 16'h000c;
    hostIso <= 1'b1;
    host.token(TOK_IN, 4'h2, funcAddr);
    #1 check("txSend", 8'h01, txSend);
    waitDone(1'b1, 1'b0);
    chkRd(EPC_BASE + 16'h2, 8'ha0);
    // A slow host that never ACKs: no release, toggle kept.
    regWrite(EPC_BASE + 16'h2, 8'h20);
    {hostIso, ackOn, gap} <= {2'h0, 4'h5};
    host.token(TOK_IN, 4'h2, funcAddr);
    waitDone(1'b0, 1'b0);
    chkRd(EPC_BASE + 16'h2, 8'h20);
    // Writes during a transaction are parked; the last one wins.
    {ackOn, gap} <= 5'h18;
    host.token(TOK_IN, 4'h3, funcAddr);
    regWrite(EPC_BASE + 16'h3, 8'h08);
    regWrite(EPC_BASE + 16'h3, 8'h28);
    chkRd(EPC_BASE + 16'h3, 8'h20);
    waitDone(1'b1, 1'b1);
    chkRd(EPC_BASE + 16'h3, 8'h28);
    // Toggle history, repeated toggle, and isochronous receive.
    regWrite(EPC_BASE + 16'h1, 8'h10);
    rxOk <= 1'b1;
    outTxn(4'h1, 1'b1, 1'b0);
    chkRd(EPC_BASE + 16'h1, 8'h11);
    outTxn(4'h1, 1'b1, 1'b1);
    regWrite(EPC_BASE + 16'h1, 8'h50);
    outTxn(4'h1, 1'b1, 1'b0);
    chkRd(EPC_BASE + 16'h1, 8'h51);
    // Read-only bit, unmapped places and the window's last byte.
    regWrite(EPC_LAST, 8'hff);
    chkRd(EPC_LAST, 8'hfe);
    regWrite(16'h7f90, 8'h5a);
    chkRd(16'h7f90, 8'h00);
    chkRd(16'h7f7f, 8'h00);
    // Reset again in mid-run.
    doReset();
    chkRd(EPC_LAST, EPC_RESET);
    check("hsValid", 8'h00, hsValid);
    conclude();
  end
endmodule
